// ===== tb/uart_peer.sv
`timescale 1ns/1ps
module uart_peer (
  input  wire logic clk_i,      // System clock
  output logic      rx_line_o,  // Line into the port
  output logic      cts_n_o     // Clear-to-send, low
);
  // Mark level while idle, permission given
  initial begin
    rx_line_o = 1'b1;
    cts_n_o   = 1'b0;
  end
  // One frame of 16 clocks a bit, as BAUD 0 gives
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line_o <= f[i];
      repeat (16) @(posedge clk_i);
    end
  endtask : send
endmodule : uart_peer

// ===== tb/uart_port_checker.sv
`timescale 1ns/1ps
module uart_port_checker (
  input wire logic        CLK_I,                      // Clock
  input wire logic        RESET_I,                    // Reset
  input wire logic        CE_I,                       // Enable
  input wire logic        CYC_I,                      // Cycle
  input wire logic        STB_I,                      // Strobe
  input wire logic        WE_I,                       // Write
  input wire logic [7:0]  ADR_I,                      // Address
  input wire logic [3:0]  SEL_I,                      // Lanes
  input wire logic [31:0] DAT_I,                      // Write data
  input wire logic        ACK_O,                      // Ack
  input wire logic        SERIAL_TX_LINE_O,           // Tx pin
  input wire logic        CLEAR_TO_SEND_INPUT_N_I,    // Clear
  input wire logic        REQUEST_TO_SEND_OUTPUT_N_O  // Request
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic [4:0] ctl_reg;   // Shadow of control bits
  logic [4:0] ctl_next;  // Next shadow
  // Shadow follows acknowledged control writes only
  always_comb begin
    ctl_next = ctl_reg;
    if (CYC_I && STB_I && WE_I && ACK_O && SEL_I[0] &&
        ADR_I[7:2] == uart_pkg::CTRL_OFF[7:2]) begin
      ctl_next = DAT_I[4:0];
    end
  end
  always_ff @(posedge CLK_I) begin
    ctl_reg <= RESET_I ? 5'h00 : ctl_next;
  end
  AST_RST_IDLE: assert property ($fell(RESET_I) |-> SERIAL_TX_LINE_O
    && REQUEST_TO_SEND_OUTPUT_N_O) else $error("pins not idle at reset");
  AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  AST_ACK_TAKEN: assert property (CE_I && CYC_I && STB_I && !ACK_O
    |=> ACK_O) else $error("request not acked next cycle");
  AST_ACK_IDLE: assert property (!(CYC_I && STB_I) |=> !ACK_O)
    else $error("ack without request");
  AST_START_LEN: assert property ($fell(SERIAL_TX_LINE_O)
    |=> !SERIAL_TX_LINE_O [*8]) else $error("start cell too short");
  AST_HIGH_CELL: assert property ($rose(SERIAL_TX_LINE_O)
    |=> SERIAL_TX_LINE_O [*8]) else $error("high cell too short");
  AST_CTS_GATE: assert property ((ctl_reg[3] &&
    CLEAR_TO_SEND_INPUT_N_I) [*6] |-> !$fell(SERIAL_TX_LINE_O))
    else $error("start while clear-to-send negated");
  AST_RTS_BUSY: assert property (!ctl_reg[4] && !SERIAL_TX_LINE_O
    && $past(SERIAL_TX_LINE_O) == 1'b0 |-> !REQUEST_TO_SEND_OUTPUT_N_O)
    else $error("request high while sending");
endmodule : uart_port_checker
bind uart_serial_port uart_port_checker u_chk (.*);

// ===== tb/uart_serial_port_tb.sv
`timescale 1ns/1ps
module uart_serial_port_tb;
  logic clk, rst, cyc, stb, we, ack, tx, rts_n, rx, cts_n;  // Pins
  logic [7:0]  adr, b, g;   // Address, bytes
  logic [3:0]  sel;         // Lanes
  logic [31:0] dat, dout, q; // Bus data
  int          error_cnt;   // Mismatches
  int          n_compared;  // Comparisons
  uart_serial_port u_dut (.CLK_I(clk), .RESET_I(rst), .CE_I(1'b1),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dat), .DAT_O(dout), .ACK_O(ack), .SERIAL_RX_LINE_I(rx),
    .CLEAR_TO_SEND_INPUT_N_I(cts_n), .SERIAL_TX_LINE_O(tx),
    .REQUEST_TO_SEND_OUTPUT_N_O(rts_n));
  uart_peer u_peer (.clk_i(clk), .rx_line_o(rx), .cts_n_o(cts_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic close_out;
    $display("Compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    n_compared++;
    if (v !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  // Classic cycle held until ack, then released for a cycle
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dout;
    if (n >= 20) error_cnt++;
    if (n >= 20) close_out();
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask : wb
  // Capture one frame from the transmit pin at bit centres
  task automatic grab(output logic [7:0] c);
    int n;
    for (n = 0; tx !== 1'b0 && n < 2000; n++) @(posedge clk);
    if (n >= 2000) error_cnt++;
    if (n >= 2000) close_out();
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk);
      c[i] = tx;
    end
    repeat (16) @(posedge clk);
    chk("stop", 32'h1, {31'h0, tx});
  endtask : grab
  initial begin
    {rst, cyc, stb, we, adr, sel, dat, error_cnt, n_compared} = '0;
    rst = 1'b1;
    void'($urandom(32'hd7e858bf));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, uart_pkg::BAUD_OFF, 32'h0);
    chk("baud", {16'h0, uart_pkg::BAUD_RST}, q);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b1, uart_pkg::BAUD_OFF, 32'h0);
    wb(1'b1, uart_pkg::CTRL_OFF, 32'h3);
    b = 8'($urandom());
    wb(1'b1, uart_pkg::TXD_OFF, {24'h0, b});
    grab(g);
    chk("tx byte", {24'h0, b}, {24'h0, g});
    b = 8'($urandom());
    u_peer.send(b);
    repeat (20) @(posedge clk);
    wb(1'b0, uart_pkg::RXD_OFF, 32'h0);
    chk("rx byte", {24'h0, b}, q);
    wb(1'b0, uart_pkg::RXD_OFF, 32'h0);
    chk("rx empty", 32'h0, q);
    // Permission withheld: the held byte must wait
    u_peer.cts_n_o <= 1'b1;
    wb(1'b1, uart_pkg::CTRL_OFF, 32'h9);
    wb(1'b1, uart_pkg::TXD_OFF, 32'hA5);
    repeat (200) @(posedge clk);
    chk("tx waits", 32'h1, {31'h0, tx});
    u_peer.cts_n_o <= 1'b0;
    grab(g);
    chk("tx after cts", 32'hA5, {24'h0, g});
    // Loopback keeps the pin at mark yet feeds the receiver
    wb(1'b1, uart_pkg::CTRL_OFF, 32'h7);
    wb(1'b1, uart_pkg::TXD_OFF, 32'h3C);
    g = 8'h1;
    repeat (220) @(posedge clk) g = g & {7'h0, tx};
    chk("loop mark", 32'h1, {24'h0, g});
    wb(1'b0, uart_pkg::RXD_OFF, 32'h0);
    chk("loop byte", 32'h3C, q);
    // Request follows queue fill against a level of two
    wb(1'b1, uart_pkg::RTSL_OFF, 32'h2);
    wb(1'b1, uart_pkg::CTRL_OFF, 32'h12);
    // Request pin is registered a cycle after the control write lands
    @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      chk("rts", 32'h0, {31'h0, rts_n});
      u_peer.send(8'($urandom()));
      repeat (20) @(posedge clk);
    end
    chk("rts full", 32'h1, {31'h0, rts_n});
    // Two bytes queued, clear-to-send asserted, nothing else set
    wb(1'b0, uart_pkg::STAT_OFF, 32'h0);
    chk("status", 32'h284, q);
    // Stopped port clock wakes on receive activity
    wb(1'b1, uart_pkg::CTRL_OFF, 32'h22);
    wb(1'b0, uart_pkg::CTRL_OFF, 32'h0);
    chk("stopped", 32'h22, q);
    u_peer.send(8'h55);
    wb(1'b0, uart_pkg::CTRL_OFF, 32'h0);
    chk("woken", 32'h2, q);
    close_out();
  end
endmodule : uart_serial_port_tb

// ===== verilog/uart_bit_clock.sv
`timescale 1ns/1ps
module uart_bit_clock (
  input  wire logic        clk_i,  // System clock
  input  wire logic        rst_i,  // Synchronous reset
  input  wire logic        ce_i,   // Clock enable
  input  wire logic        run_i,  // Port clock running
  input  wire logic [15:0] div_i,  // Cycles per oversample tick, less one
  output logic             tick_o, // Oversample tick, one cycle
  output logic             fall_o  // Serial clock falling edge
);

  // ----------------------------------------------------------------
  // Divider and 16-phase serial clock
  // ----------------------------------------------------------------
  logic [15:0] cnt_reg;    // Divider count
  logic [15:0] cnt_next;   // Next divider count
  logic [3:0]  phase_reg;  // Phase inside a bit cell
  logic [3:0]  phase_next; // Next phase
  logic        tick_next;  // Next tick pulse
  logic        fall_next;  // Next falling edge pulse

  // Serial clock is high for phases 0..7 and falls leaving phase 7;
  // a stopped port clock freezes the phase where it stands
  always_comb begin
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    tick_next  = 1'b0;
    fall_next  = 1'b0;
    if (run_i) begin
      if (cnt_reg >= div_i) begin
        cnt_next   = 16'h0000;
        tick_next  = 1'b1;
        phase_next = phase_reg + 4'h1;
        fall_next  = (phase_reg == uart_pkg::MID_PHASE);
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  // Register divider state and pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg   <= 16'h0000;
      phase_reg <= 4'h0;
      tick_o    <= 1'b0;
      fall_o    <= 1'b0;
    end else if (ce_i) begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
      tick_o    <= tick_next;
      fall_o    <= fall_next;
    end
  end

endmodule : uart_bit_clock

// ===== verilog/uart_pkg.sv
package uart_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;  // Control bits
  localparam logic [7:0] BAUD_OFF = 8'h04;  // Oversample divisor
  localparam logic [7:0] STAT_OFF = 8'h08;  // Status, sticky w1c
  localparam logic [7:0] TXD_OFF  = 8'h0C;  // Transmit holding byte
  localparam logic [7:0] RXD_OFF  = 8'h10;  // Receive queue head, pops
  localparam logic [7:0] RTSL_OFF = 8'h14;  // Flow control level

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned STOP_BIT  = 5;        // Port clock stop bit
  localparam int unsigned OVR_BIT   = 4;        // Overrun in status
  localparam int unsigned FERR_BIT  = 5;        // Framing err in status
  localparam int unsigned CTRL_W    = 5;        // Width of ctrl_t
  localparam int unsigned STAT_W    = 12;       // Width of stat_t
  localparam logic [4:0]  CTRL_RST  = 5'h00;    // All functions off
  localparam logic [15:0] BAUD_RST  = 16'h0015; // Near 115200 at 40 MHz
  localparam logic [3:0]  RTSL_RST  = 4'h6;     // Negate request at 6

  // ----------------------------------------------------------------
  // Character and timing counts
  // ----------------------------------------------------------------
  localparam int unsigned DATA_BITS  = 8;     // Bits per character
  localparam logic [3:0]  MID_PHASE  = 4'h7;  // Centre of a bit cell
  localparam logic [3:0]  LAST_PHASE = 4'hF;  // Last of 16 phases
  localparam logic [3:0]  TX_BITS    = 4'h9;  // Data plus stop bit
  localparam logic [2:0]  LAST_DBIT  = 3'h7;  // Index of last data bit
  localparam int unsigned Q_DEPTH    = 8;     // Receive queue words
  localparam int unsigned Q_AW       = 3;     // Queue pointer width
  localparam logic [3:0]  Q_FULL     = 4'h8;  // Count when full

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rts_auto;  // Request follows queue fill
    logic cts_en;    // Wait for clear-to-send
    logic loopback;  // Local loopback
    logic rx_en;     // Receiver on
    logic tx_en;     // Transmitter on
  } ctrl_t;

  typedef struct packed {
    logic [3:0] count;       // Queue fill
    logic       cts;         // Clear-to-send asserted
    logic       stopped;     // Port clock stopped
    logic       frame_err;   // Stop bit seen low
    logic       overrun;     // Character lost, queue full
    logic       rx_full;     // Queue full
    logic       rx_nonempty; // Queue holds data
    logic       hold_full;   // Holding byte waiting
    logic       tx_busy;     // Character on the line
  } stat_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_t;

endpackage : uart_pkg

// ===== verilog/uart_serial_port.sv
// Functional notes
// - Transmit line high when off, idle, looped
// - Shift out LSB first on clock fall
// - Receive characters assembled LSB first
// - Receive line transition restarts stopped clock
// - Clear-to-send gates start of transmission
// - Request-to-send driven by port logic
// - Request-to-send follows receive queue fill
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module uart_serial_port (
  input  wire logic        CLK_I,                       // Clock 40 MHz
  input  wire logic        RESET_I,                     // Sync reset
  input  wire logic        CE_I,                        // Clock enable
  input  wire logic        CYC_I,                       // Bus cycle
  input  wire logic        STB_I,                       // Bus strobe
  input  wire logic        WE_I,                        // Write
  input  wire logic [7:0]  ADR_I,                       // Byte address
  input  wire logic [3:0]  SEL_I,                       // Byte lanes
  input  wire logic [31:0] DAT_I,                       // Write data
  output logic      [31:0] DAT_O,                       // Read data
  output logic             ACK_O,                       // Acknowledge
  input  wire logic        SERIAL_RX_LINE_I,            // Receive pin
  input  wire logic        CLEAR_TO_SEND_INPUT_N_I,     // Clear, low
  output logic             SERIAL_TX_LINE_O,            // Transmit pin
  output logic             REQUEST_TO_SEND_OUTPUT_N_O   // Request, low
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merge write data into an old value by byte lane
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // Word address match, low two bits ignored
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : hit

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  uart_pkg::ctrl_t     ctrl_reg, ctrl_next;     // Control bits
  logic                stop_reg, stop_next;     // Port clock stopped
  logic [15:0]         baud_reg, baud_next;     // Divisor
  logic [3:0]          rtsl_reg, rtsl_next;     // Flow level
  logic                ovr_reg, ovr_next;       // Sticky overrun
  logic                ferr_reg, ferr_next;     // Sticky framing
  logic [31:0]         dat_next;                // Next read data
  logic                ack_next;                // Next acknowledge
  logic [7:0]          hold_reg, hold_next;     // Holding byte
  logic                hfull_reg, hfull_next;   // Holding byte valid
  logic [8:0]          sh_reg, sh_next;         // Transmit shifter
  logic [3:0]          bits_reg, bits_next;     // Bits left to send
  logic                line_reg, line_next;     // Internal tx level
  logic                txp_next;                // Next pin level
  logic                rts_n_next;              // Next request level
  uart_pkg::rx_state_t rx_st_reg, rx_st_next;   // Receiver state
  logic [3:0]          ph_reg, ph_next;         // Receive phase
  logic [2:0]          rbit_reg, rbit_next;     // Data bit index
  logic [7:0]          rsh_reg, rsh_next;       // Receive shifter
  logic                rxp_reg;                 // Previous rx level
  logic [7:0]          q_mem [uart_pkg::Q_DEPTH]; // Receive queue
  logic [2:0]          wp_reg, wp_next;         // Write pointer
  logic [2:0]          rp_reg, rp_next;         // Read pointer
  logic [3:0]          cnt_reg, cnt_next;       // Queue fill
  logic [1:0]          sync_q;                  // Synced rx and cts
  logic                req, take, wr, rd;       // Bus decode
  logic                tick, fall;              // Timing pulses
  logic                rx_s, cts_ok, rx_in;     // Line views
  logic                push, pop, edge_seen;    // Events
  logic                start_ok;                // May start a char
  logic                frame_end;               // Stop bit sampled
  uart_pkg::stat_t     stat;                    // Status view

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Pins from the peer pass two flip-flops first
  uart_sync #(.WIDTH(2)) u_sync (
    .clk_i (CLK_I),
    .rst_i (RESET_I),
    .ce_i  (CE_I),
    .d_i   ({CLEAR_TO_SEND_INPUT_N_I, SERIAL_RX_LINE_I}),
    .q_o   (sync_q)
  );

  // Bit timing halts while the port clock is stopped
  uart_bit_clock u_clk (
    .clk_i  (CLK_I),
    .rst_i  (RESET_I),
    .ce_i   (CE_I),
    .run_i  (!stop_reg),
    .div_i  (baud_reg),
    .tick_o (tick),
    .fall_o (fall)
  );

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  always_comb begin
    rx_s      = sync_q[0];
    cts_ok    = !ctrl_reg.cts_en || !sync_q[1];
    rx_in     = ctrl_reg.loopback ? line_reg : rx_s;
    req       = CYC_I && STB_I;
    take      = req && ACK_O;      // Edge where the master samples ack
    wr        = take && WE_I;
    rd        = take && !WE_I;
    edge_seen = rx_s ^ rxp_reg;    // Reads the second stage only
    frame_end = (rx_st_reg == uart_pkg::RX_STOP) && tick &&
                (ph_reg == uart_pkg::LAST_PHASE);
    push      = frame_end && rx_in && (cnt_reg != uart_pkg::Q_FULL);
    pop       = rd && hit(ADR_I, uart_pkg::RXD_OFF) && SEL_I[0] &&
                (cnt_reg != 4'h0);
    start_ok  = hfull_reg && ctrl_reg.tx_en && cts_ok;
    stat.count       = cnt_reg;
    stat.cts         = !sync_q[1];
    stat.stopped     = stop_reg;
    stat.frame_err   = ferr_reg;
    stat.overrun     = ovr_reg;
    stat.rx_full     = cnt_reg == uart_pkg::Q_FULL;
    stat.rx_nonempty = cnt_reg != 4'h0;
    stat.hold_full   = hfull_reg;
    stat.tx_busy     = bits_reg != 4'h0;
  end

  // ----------------------------------------------------------------
  // Bus slave: ack one cycle after the request, dropped next cycle
  // ----------------------------------------------------------------
  always_comb begin
    ack_next = req && !ACK_O;
    dat_next = DAT_O;
    if (req && !ACK_O) begin
      // Read data snapshot; unmapped words read zero
      dat_next = 32'h0000_0000;
      if (hit(ADR_I, uart_pkg::CTRL_OFF)) begin
        dat_next[uart_pkg::CTRL_W-1:0] = ctrl_reg;
        dat_next[uart_pkg::STOP_BIT]   = stop_reg;
      end else if (hit(ADR_I, uart_pkg::BAUD_OFF)) begin
        dat_next[15:0] = baud_reg;
      end else if (hit(ADR_I, uart_pkg::STAT_OFF)) begin
        dat_next[uart_pkg::STAT_W-1:0] = stat;
      end else if (hit(ADR_I, uart_pkg::RXD_OFF)) begin
        dat_next[7:0] = (cnt_reg != 4'h0) ? q_mem[rp_reg] : 8'h00;
      end else if (hit(ADR_I, uart_pkg::RTSL_OFF)) begin
        dat_next[3:0] = rtsl_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers and sticky flags
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    m          = merge(32'h0000_0000, DAT_I, SEL_I);
    ctrl_next  = ctrl_reg;
    stop_next  = stop_reg;
    baud_next  = baud_reg;
    rtsl_next  = rtsl_reg;
    ovr_next   = ovr_reg;
    ferr_next  = ferr_reg;
    if (wr && hit(ADR_I, uart_pkg::CTRL_OFF) && SEL_I[0]) begin
      ctrl_next = m[uart_pkg::CTRL_W-1:0];
      stop_next = m[uart_pkg::STOP_BIT];
    end
    if (wr && hit(ADR_I, uart_pkg::BAUD_OFF)) begin
      baud_next = 16'(merge({16'h0000, baud_reg}, DAT_I, SEL_I));
    end
    if (wr && hit(ADR_I, uart_pkg::RTSL_OFF) && SEL_I[0]) begin
      rtsl_next = m[3:0];
    end
    // Write one to clear; a new event in the same cycle wins
    if (wr && hit(ADR_I, uart_pkg::STAT_OFF) && SEL_I[0]) begin
      if (m[uart_pkg::OVR_BIT]) ovr_next = 1'b0;
      if (m[uart_pkg::FERR_BIT]) ferr_next = 1'b0;
    end
    if (frame_end && rx_in && (cnt_reg == uart_pkg::Q_FULL)) begin
      ovr_next = 1'b1;
    end
    if (frame_end && !rx_in) ferr_next = 1'b1;
    // Activity on the pin wakes the port even against a stop write
    if (stop_reg && edge_seen) stop_next = 1'b0;
  end

  // ----------------------------------------------------------------
  // Transmitter: shifter driven from serial clock falling edges
  // ----------------------------------------------------------------
  always_comb begin
    hold_next  = hold_reg;
    hfull_next = hfull_reg;
    sh_next    = sh_reg;
    bits_next  = bits_reg;
    line_next  = line_reg;
    // A byte written while the holder is full is dropped
    if (wr && hit(ADR_I, uart_pkg::TXD_OFF) && SEL_I[0] && !hfull_reg)
    begin
      hold_next  = DAT_I[7:0];
      hfull_next = 1'b1;
    end
    if (!ctrl_reg.tx_en) begin
      bits_next = 4'h0;            // Disable aborts the character
      line_next = 1'b1;
    end else if (fall) begin
      if (bits_reg != 4'h0) begin
        line_next = sh_reg[0];
        sh_next   = {1'b1, sh_reg[8:1]};
        bits_next = bits_reg - 4'h1;
      end else if (start_ok) begin
        line_next  = 1'b0;         // Start bit
        sh_next    = {1'b1, hold_reg};  // Data then stop bit
        bits_next  = uart_pkg::TX_BITS;
        hfull_next = 1'b0;
      end else begin
        line_next = 1'b1;          // Idle at mark
      end
    end
    // Pin stays at mark when off or looped back
    txp_next = (ctrl_reg.tx_en && !ctrl_reg.loopback) ?
               line_next : 1'b1;
    // Request to send, active low, from port logic alone
    if (ctrl_reg.rts_auto) begin
      rts_n_next = !(ctrl_reg.rx_en && (cnt_reg < rtsl_reg));
    end else begin
      rts_n_next = !(hfull_reg || (bits_reg != 4'h0));
    end
  end

  // ----------------------------------------------------------------
  // Receiver: 16x oversampled, centre sampling
  // ----------------------------------------------------------------
  always_comb begin
    rx_st_next = rx_st_reg;
    ph_next    = ph_reg;
    rbit_next  = rbit_reg;
    rsh_next   = rsh_reg;
    if (!ctrl_reg.rx_en) begin
      rx_st_next = uart_pkg::RX_IDLE;
    end else if (tick) begin
      ph_next = ph_reg + 4'h1;
      case (rx_st_reg)
        uart_pkg::RX_IDLE: begin
          ph_next = 4'h0;
          if (!rx_in) rx_st_next = uart_pkg::RX_START;
        end
        uart_pkg::RX_START: begin
          // Glitch shorter than half a bit is rejected
          if (ph_reg == uart_pkg::MID_PHASE) begin
            ph_next    = 4'h0;
            rbit_next  = 3'h0;
            rx_st_next = rx_in ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          end
        end
        uart_pkg::RX_DATA: begin
          if (ph_reg == uart_pkg::LAST_PHASE) begin
            rsh_next  = {rx_in, rsh_reg[7:1]};
            rbit_next = rbit_reg + 3'h1;
            if (rbit_reg == uart_pkg::LAST_DBIT) begin
              rx_st_next = uart_pkg::RX_STOP;
            end
          end
        end
        uart_pkg::RX_STOP: begin
          if (ph_reg == uart_pkg::LAST_PHASE) begin
            rx_st_next = uart_pkg::RX_IDLE;
          end
        end
        default: rx_st_next = uart_pkg::RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive queue pointers
  // ----------------------------------------------------------------
  always_comb begin
    wp_next  = push ? wp_reg + 3'h1 : wp_reg;
    rp_next  = pop ? rp_reg + 3'h1 : rp_reg;
    cnt_next = cnt_reg;
    if (push && !pop) cnt_next = cnt_reg + 4'h1;
    if (pop && !push) cnt_next = cnt_reg - 4'h1;
  end

  // Queue storage, no reset needed
  always_ff @(posedge CLK_I) begin
    if (CE_I && push) q_mem[wp_reg] <= rsh_reg;
  end

  // ----------------------------------------------------------------
  // State registers; CE_I low freezes everything
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ACK_O                      <= 1'b0;
      DAT_O                      <= 32'h0000_0000;
      ctrl_reg                   <= uart_pkg::CTRL_RST;
      stop_reg                   <= 1'b0;
      baud_reg                   <= uart_pkg::BAUD_RST;
      rtsl_reg                   <= uart_pkg::RTSL_RST;
      ovr_reg                    <= 1'b0;
      ferr_reg                   <= 1'b0;
      hold_reg                   <= 8'h00;
      hfull_reg                  <= 1'b0;
      sh_reg                     <= 9'h1FF;
      bits_reg                   <= 4'h0;
      line_reg                   <= 1'b1;
      SERIAL_TX_LINE_O           <= 1'b1;
      REQUEST_TO_SEND_OUTPUT_N_O <= 1'b1;
      rx_st_reg                  <= uart_pkg::RX_IDLE;
      ph_reg                     <= 4'h0;
      rbit_reg                   <= 3'h0;
      rsh_reg                    <= 8'h00;
      rxp_reg                    <= 1'b1;
      wp_reg                     <= 3'h0;
      rp_reg                     <= 3'h0;
      cnt_reg                    <= 4'h0;
    end else if (CE_I) begin
      ACK_O                      <= ack_next;
      DAT_O                      <= dat_next;
      ctrl_reg                   <= ctrl_next;
      stop_reg                   <= stop_next;
      baud_reg                   <= baud_next;
      rtsl_reg                   <= rtsl_next;
      ovr_reg                    <= ovr_next;
      ferr_reg                   <= ferr_next;
      hold_reg                   <= hold_next;
      hfull_reg                  <= hfull_next;
      sh_reg                     <= sh_next;
      bits_reg                   <= bits_next;
      line_reg                   <= line_next;
      SERIAL_TX_LINE_O           <= txp_next;
      REQUEST_TO_SEND_OUTPUT_N_O <= rts_n_next;
      rx_st_reg                  <= rx_st_next;
      ph_reg                     <= ph_next;
      rbit_reg                   <= rbit_next;
      rsh_reg                    <= rsh_next;
      rxp_reg                    <= rx_s;
      wp_reg                     <= wp_next;
      rp_reg                     <= rp_next;
      cnt_reg                    <= cnt_next;
    end
  end

endmodule : uart_serial_port

// ===== verilog/uart_sync.sv
`timescale 1ns/1ps
module uart_sync #(
  parameter int unsigned WIDTH = 2  // Number of levels
) (
  input  wire logic             clk_i,  // System clock
  input  wire logic             rst_i,  // Synchronous reset
  input  wire logic             ce_i,   // Clock enable
  input  wire logic [WIDTH-1:0] d_i,    // Asynchronous levels
  output logic      [WIDTH-1:0] q_o     // Synchronised levels
);

  // ----------------------------------------------------------------
  // Two flip-flop synchroniser
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg;  // First stage, read only by second
  logic [WIDTH-1:0] meta_next; // Next first stage
  logic [WIDTH-1:0] q_next;    // Next second stage

  // Idle lines are high, so reset to mark
  always_comb begin
    meta_next = ce_i ? d_i : meta_reg;
    q_next    = ce_i ? meta_reg : q_o;
  end

  // Register both stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '1;
      q_o      <= '1;
    end else begin
      meta_reg <= meta_next;
      q_o      <= q_next;
    end
  end

endmodule : uart_sync
